// >>> hw/acr_pkg.sv
package acr_pkg;
  localparam logic [7:0] ADDR_PCIP    = 8'ha1;
  localparam logic [7:0] ADDR_PSEL    = 8'ha2;
  localparam logic [7:0] ADDR_TCBF    = 8'ha3;
  localparam logic [7:0] ADDR_PPR     = 8'ha4;
  localparam logic [3:0] PAGE_ZERO    = 4'h0;
  localparam logic [7:0] PCIP_RST     = 8'h00;
  localparam logic [7:0] PSEL_RST     = 8'h00;
  localparam logic [7:0] TCBF_RST     = 8'h00;
  localparam logic [7:0] PPR_RST      = 8'h00;
  localparam logic [7:0] PCIP_WMASK   = 8'he3;
  localparam logic [7:0] PSEL_WMASK   = 8'h01;
  localparam logic [7:0] TCBF_WMASK   = 8'h0f;
  localparam int         START_BIT    = 7;
  localparam int         STOP_BIT     = 6;
  localparam int         DIV12        = 12;
  localparam int         DIV48        = 48;
  localparam int         DIV192       = 192;
  localparam int         DIVW         = 8;
endpackage : acr_pkg

// >>> hw/acr_regs.sv
`timescale 1ns/1ps
module acr_regs
  import acr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [3:0] sfr_page,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       internal_rc_sel,
  input  wire logic       master_clock,
  input  wire logic       low_speed_rc,
  input  wire logic       ext_irq_zero,
  input  wire logic       ext_irq_one,
  output logic            irq0_active,
  output logic            irq1_active,
  output logic            pointer_select_bit,
  input  wire logic       start_seen,
  input  wire logic       stop_seen,
  input  wire logic       timer0_pin,
  input  wire logic       timer1_pin,
  input  wire logic       timer0_count_mode,
  input  wire logic       timer1_count_mode,
  input  wire logic       watchdog_prescaler_out,
  input  wire logic       timer1_overflow,
  input  wire logic       timer0_clkout,
  input  wire logic       timer1_clkout,
  output logic            timer0_tick,
  output logic            timer1_tick,
  output logic            timer1_clkout_pin,
  output logic      [3:0] timer0_route,
  output logic            timer0_clkout_pin,
  output logic            pin60_clock_en,
  output logic            pin60_out,
  output logic            pin60_fast_drive,
  output logic            pin44_beeper_en,
  output logic            pin44_out,
  output logic            serial0_pin_select,
  output logic      [1:0] twowire0_pin_select
);
  import acr_pkg::*;

  logic [7:0] pcip_q, pcip_d, psel_q, psel_d, tcbf_q, tcbf_d, ppr_q, ppr_d;
  logic [1:0] mdiv_q, mdiv_d;
  logic [4:0] rdiv_q, rdiv_d;
  logic [DIVW-1:0] sdiv_q, sdiv_d;
  logic [1:0] sdiv48_q, sdiv48_d;
  logic [1:0] sdiv192_q, sdiv192_d;
  logic       mc_q, rc_q, pin0_q, pin1_q, wd_q, of_q;
  logic       s12, s48, s192;
  logic       wr_pcip, wr_psel, wr_tcbf, wr_ppr;

  assign wr_pcip = sfr_wr && sfr_addr == ADDR_PCIP;
  assign wr_psel = sfr_wr && sfr_addr == ADDR_PSEL;
  assign wr_tcbf = sfr_wr && sfr_addr == ADDR_TCBF;
  assign wr_ppr  = sfr_wr && sfr_addr == ADDR_PPR
                   && sfr_page == PAGE_ZERO;

  always_comb begin
    pcip_d = pcip_q;
    psel_d = psel_q;
    tcbf_d = tcbf_q;
    ppr_d  = ppr_q;
    if (wr_pcip) begin
      pcip_d = sfr_wdata & PCIP_WMASK;
    end
    if (wr_psel) begin
      psel_d = sfr_wdata & PSEL_WMASK;
    end
    if (wr_tcbf) begin
      tcbf_d[3:0] = sfr_wdata[3:0] & TCBF_WMASK[3:0];
      if (!sfr_wdata[START_BIT]) tcbf_d[START_BIT] = 1'b0;
      if (!sfr_wdata[STOP_BIT]) tcbf_d[STOP_BIT] = 1'b0;
    end
    if (start_seen) tcbf_d[START_BIT] = 1'b1;
    if (stop_seen) tcbf_d[STOP_BIT] = 1'b1;
    if (wr_ppr) begin
      ppr_d = sfr_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcip_q <= PCIP_RST;
      psel_q <= PSEL_RST;
      tcbf_q <= TCBF_RST;
      ppr_q  <= PPR_RST;
    end else if (ce) begin
      pcip_q <= pcip_d;
      psel_q <= psel_d;
      tcbf_q <= tcbf_d;
      ppr_q  <= ppr_d;
    end
  end

  always_comb begin
    if (sfr_rd && sfr_addr == ADDR_PCIP) begin
      sfr_rdata = pcip_q;
    end else if (sfr_rd && sfr_addr == ADDR_PSEL) begin
      sfr_rdata = psel_q;
    end else if (sfr_rd && sfr_addr == ADDR_TCBF) begin
      sfr_rdata = tcbf_q;
    end else if (sfr_rd && sfr_addr == ADDR_PPR
                 && sfr_page == PAGE_ZERO) begin
      sfr_rdata = ppr_q;
    end else begin
      sfr_rdata = 8'h00;
    end
  end

  // clock dividers and input samplers
  always_comb begin
    mdiv_d    = mdiv_q;
    rdiv_d    = rdiv_q;
    sdiv_d    = sdiv_q;
    sdiv48_d  = sdiv48_q;
    sdiv192_d = sdiv192_q;
    if (mc_q && !master_clock) mdiv_d = mdiv_q + 2'h1;
    if (rc_q && !low_speed_rc) rdiv_d = rdiv_q + 5'h01;
    if (s12) begin
      sdiv_d = '0;
      sdiv48_d = sdiv48_q + 2'h1;
      if (sdiv48_q == 2'h3) sdiv192_d = sdiv192_q + 2'h1;
    end else begin
      sdiv_d = sdiv_q + 1'b1;
    end
  end

  assign s12  = sdiv_q == DIVW'(DIV12 - 1);
  assign s48  = s12 && sdiv48_q == 2'(DIV48 / DIV12 - 1);
  assign s192 = s48 && sdiv192_q == 2'(DIV192 / DIV48 - 1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mdiv_q    <= 2'h0;
      rdiv_q    <= 5'h00;
      sdiv_q    <= '0;
      sdiv48_q  <= 2'h0;
      sdiv192_q <= 2'h0;
      mc_q      <= 1'b0;
      rc_q      <= 1'b0;
      pin0_q    <= 1'b0;
      pin1_q    <= 1'b0;
      wd_q      <= 1'b0;
      of_q      <= 1'b0;
    end else if (ce) begin
      mdiv_q    <= mdiv_d;
      rdiv_q    <= rdiv_d;
      sdiv_q    <= sdiv_d;
      sdiv48_q  <= sdiv48_d;
      sdiv192_q <= sdiv192_d;
      mc_q      <= master_clock;
      rc_q      <= low_speed_rc;
      pin0_q    <= timer0_pin;
      pin1_q    <= timer1_pin;
      wd_q      <= watchdog_prescaler_out;
      of_q      <= timer1_overflow;
    end
  end

  // outputs
  always_comb begin
    pin60_clock_en = internal_rc_sel && pcip_q[7:6] != 2'h0;
    case (pcip_q[7:6])
      2'h1:    pin60_out = master_clock;
      2'h2:    pin60_out = mdiv_q[0];
      2'h3:    pin60_out = mdiv_q[1];
      default: pin60_out = 1'b0;
    endcase
    pin60_fast_drive = pcip_q[5];
    irq1_active = pcip_q[1] ? ext_irq_one : !ext_irq_one;
    irq0_active = pcip_q[0] ? ext_irq_zero : !ext_irq_zero;
    pointer_select_bit = psel_q[0];
    case ({tcbf_q[3], timer1_count_mode})
      2'h0:    timer1_tick = s12;
      2'h1:    timer1_tick = pin1_q && !timer1_pin;
      2'h2:    timer1_tick = 1'b1;
      default: timer1_tick = s48;
    endcase
    case ({ppr_q[0], tcbf_q[2], timer0_count_mode})
      3'h0:    timer0_tick = s12;
      3'h1:    timer0_tick = pin0_q && !timer0_pin;
      3'h2:    timer0_tick = 1'b1;
      3'h3:    timer0_tick = rc_q && !low_speed_rc;
      3'h4:    timer0_tick = s48;
      3'h5:    timer0_tick = wd_q && !watchdog_prescaler_out;
      3'h6:    timer0_tick = s192;
      default: timer0_tick = of_q && !timer1_overflow;
    endcase
    timer1_clkout_pin = tcbf_q[1] & timer1_clkout;
    timer0_clkout_pin = tcbf_q[0] & timer0_clkout;
    timer0_route = 4'h1 << ppr_q[7:6];
    pin44_beeper_en = ppr_q[5:4] != 2'h0;
    case (ppr_q[5:4])
      2'h1:    pin44_out = rdiv_q[4];
      2'h2:    pin44_out = rdiv_q[3];
      2'h3:    pin44_out = rdiv_q[2];
      default: pin44_out = 1'b0;
    endcase
    serial0_pin_select = ppr_q[3];
    twowire0_pin_select = ppr_q[2:1];
  end

  a_start_flag_set: assert property (@(posedge clk) disable iff (rst)
    ce && start_seen |=> tcbf_q[START_BIT])
    else $error("start flag not set");
  a_stop_flag_set: assert property (@(posedge clk) disable iff (rst)
    ce && stop_seen |=> tcbf_q[STOP_BIT])
    else $error("stop flag not set");
  a_page_guard: assert property (@(posedge clk) disable iff (rst)
    ce && sfr_wr && sfr_addr == ADDR_PPR && sfr_page != PAGE_ZERO
    |=> $stable(ppr_q))
    else $error("pin routing written off page zero");
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    pcip_q[4:2] == 3'h0 && psel_q[7:1] == 7'h0 && tcbf_q[5:4] == 2'h0)
    else $error("reserved bit set");
  a_ptr_write: assert property (@(posedge clk) disable iff (rst)
    ce && wr_psel |=> pointer_select_bit == $past(sfr_wdata[0]))
    else $error("pointer select not updated");
  a_irq0_pol: assert property (@(posedge clk) disable iff (rst)
    irq0_active == (ext_irq_zero ~^ pcip_q[0]))
    else $error("irq0 polarity wrong");
  a_irq1_pol: assert property (@(posedge clk) disable iff (rst)
    irq1_active == (ext_irq_one ~^ pcip_q[1]))
    else $error("irq1 polarity wrong");
  a_p60_gate: assert property (@(posedge clk) disable iff (rst)
    !internal_rc_sel |-> !pin60_clock_en)
    else $error("p6.0 clock out without rc source");

  // flag clear and divider steps
  sequence s_start_clear;
    ce && wr_tcbf && !sfr_wdata[START_BIT] && !start_seen;
  endsequence
  sequence s_stop_clear;
    ce && wr_tcbf && !sfr_wdata[STOP_BIT] && !stop_seen;
  endsequence
  sequence s_mclk_fall_div2;
    ce && mc_q && !master_clock && pcip_q[7:6] == 2'h2 && !wr_pcip;
  endsequence

  a_start_clear: assert property (@(posedge clk) disable iff (rst)
    s_start_clear |=> !tcbf_q[START_BIT])
    else $error("start flag not cleared");
  a_stop_clear: assert property (@(posedge clk) disable iff (rst)
    s_stop_clear |=> !tcbf_q[STOP_BIT])
    else $error("stop flag not cleared");
  a_p60_div2: assert property (@(posedge clk) disable iff (rst)
    s_mclk_fall_div2 |=> pin60_out != $past(pin60_out))
    else $error("p6.0 half clock did not toggle");
  a_p60_enable: assert property (@(posedge clk) disable iff (rst)
    internal_rc_sel && pcip_q[7:6] != 2'h0 |-> pin60_clock_en)
    else $error("p6.0 clock out not enabled");
  a_p60_direct: assert property (@(posedge clk) disable iff (rst)
    pcip_q[7:6] == 2'h1 |-> pin60_out == master_clock)
    else $error("p6.0 master clock not passed");

  a_beeper_en: assert property (@(posedge clk) disable iff (rst)
    ppr_q[5:4] != 2'h0 |-> pin44_beeper_en)
    else $error("beeper not enabled");
  a_t1_sys: assert property (@(posedge clk) disable iff (rst)
    tcbf_q[3] && !timer1_count_mode |-> timer1_tick)
    else $error("timer1 system clock tick missing");
  a_t0_sys: assert property (@(posedge clk) disable iff (rst)
    !ppr_q[0] && tcbf_q[2] && !timer0_count_mode |-> timer0_tick)
    else $error("timer0 system clock tick missing");
  a_t1_ckout_off: assert property (@(posedge clk) disable iff (rst)
    !tcbf_q[1] |-> !timer1_clkout_pin)
    else $error("timer1 clock out while disabled");
  a_t0_ckout_off: assert property (@(posedge clk) disable iff (rst)
    !tcbf_q[0] |-> !timer0_clkout_pin)
    else $error("timer0 clock out while disabled");
  a_route_onehot: assert property (@(posedge clk) disable iff (rst)
    $onehot(timer0_route))
    else $error("timer0 route not one-hot");

  a_ce_freeze: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(pcip_q) && $stable(psel_q) && $stable(tcbf_q)
    && $stable(ppr_q))
    else $error("register changed while clock enable low");
endmodule : acr_regs

// >>> tb/acr_regs_tb.sv
`timescale 1ns/1ps
module acr_regs_tb;
  import acr_pkg::*;
  logic       clk, rst, ce, sfr_wr, sfr_rd, internal_rc_sel;
  logic       master_clock, low_speed_rc, ext_irq_zero, ext_irq_one;
  logic       start_seen, stop_seen, timer0_pin, timer1_pin;
  logic       watchdog_prescaler_out, timer1_overflow;
  logic       timer0_count_mode, timer1_count_mode;
  logic       timer0_clkout, timer1_clkout;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [3:0] sfr_page, timer0_route;
  logic       irq0_active, irq1_active, pointer_select_bit, timer0_tick;
  logic       timer1_tick, timer1_clkout_pin, timer0_clkout_pin;
  logic       pin60_clock_en, pin60_out, pin60_fast_drive, pin44_beeper_en;
  logic       pin44_out, serial0_pin_select;
  logic [1:0] twowire0_pin_select;
  logic [7:0] exp_q[$];
  int         miscompares, checked, cycles, seed, ph;
  localparam int TLEN    = 192;
  localparam int MCK_PER = 4;
  localparam int RC_PER  = 6;
  acr_regs acr_regs_i (.clk(clk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .internal_rc_sel(internal_rc_sel), .master_clock(master_clock),
    .low_speed_rc(low_speed_rc), .ext_irq_zero(ext_irq_zero),
    .ext_irq_one(ext_irq_one), .irq0_active(irq0_active),
    .irq1_active(irq1_active), .pointer_select_bit(pointer_select_bit),
    .start_seen(start_seen), .stop_seen(stop_seen), .timer0_pin(timer0_pin),
    .timer1_pin(timer1_pin), .watchdog_prescaler_out(watchdog_prescaler_out),
    .timer0_count_mode(timer0_count_mode),
    .timer1_count_mode(timer1_count_mode),
    .timer1_overflow(timer1_overflow), .timer0_clkout(timer0_clkout),
    .timer1_clkout(timer1_clkout), .timer0_tick(timer0_tick),
    .timer1_tick(timer1_tick), .timer1_clkout_pin(timer1_clkout_pin),
    .timer0_route(timer0_route), .timer0_clkout_pin(timer0_clkout_pin),
    .pin60_clock_en(pin60_clock_en), .pin60_out(pin60_out),
    .pin60_fast_drive(pin60_fast_drive), .pin44_beeper_en(pin44_beeper_en),
    .pin44_out(pin44_out), .serial0_pin_select(serial0_pin_select),
    .twowire0_pin_select(twowire0_pin_select));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_rd
  task cmp_out(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_out
  task cmp_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_cnt
  function logic probe(input logic which);
    probe = which ? pin44_out : pin60_out;
  endfunction : probe
  function logic src(input logic which, input int m);
    if (which) src = timer1_pin;
    else begin
      case (m)
        1:       src = timer0_pin;
        3:       src = low_speed_rc;
        5:       src = watchdog_prescaler_out;
        default: src = timer1_overflow;
      endcase
    end
  endfunction : src
  function int exp_ticks(input logic which, input int m);
    case (m)
      0:       exp_ticks = TLEN / DIV12;
      2:       exp_ticks = TLEN;
      3:       exp_ticks = which ? TLEN / DIV48 : -1;
      4:       exp_ticks = TLEN / DIV48;
      6:       exp_ticks = TLEN / DIV192;
      default: exp_ticks = -1;
    endcase
  endfunction : exp_ticks
  task ticks(input logic which, input int m);
    int   n;
    int   f;
    int   e;
    logic prev;
    n = 0;
    f = 0;
    @(negedge clk);
    prev = src(which, m);
    repeat (TLEN) begin
      @(negedge clk);
      n = n + int'(which ? timer1_tick : timer0_tick);
      f = f + int'(prev && !src(which, m));
      prev = src(which, m);
    end
    e = exp_ticks(which, m);
    if (e < 0) e = f;
    cmp_cnt(n, e);
  endtask : ticks
  task period(input logic which, input int exp);
    logic prev;
    int   n;
    int   r;
    n = 0;
    r = 0;
    @(negedge clk);
    prev = probe(which);
    while (r < 2) begin
      @(negedge clk);
      if (probe(which) && !prev) r++;
      if (r == 1) n++;
      prev = probe(which);
    end
    cmp_cnt(n, exp);
  endtask : period
  task wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a; sfr_page <= p; sfr_wdata <= d; sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [3:0] p, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a; sfr_page <= p; sfr_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    sfr_rd <= 1'b0;
  endtask : rd
  task pulse(input logic which);
    @(posedge clk);
    if (which) start_seen <= 1'b1; else stop_seen <= 1'b1;
    @(posedge clk);
    start_seen <= 1'b0; stop_seen <= 1'b0;
  endtask : pulse
  function logic [7:0] wm(input logic [7:0] a);
    case (a)
      ADDR_PCIP: wm = PCIP_WMASK;
      ADDR_PSEL: wm = PSEL_WMASK;
      ADDR_TCBF: wm = TCBF_WMASK;
      default:   wm = 8'hff;
    endcase
  endfunction : wm
  always @(posedge clk) begin
    if (sfr_rd === 1'b1 && exp_q.size() > 0) cmp_rd(sfr_rdata, exp_q.pop_front());
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      report_and_stop;
    end
  end
  always @(posedge clk) begin
    ph <= ph + 1;
    master_clock <= ph[1];
    low_speed_rc <= (ph % RC_PER) < (RC_PER / 2);
    if (ph[0]) begin
      timer0_pin <= $random(seed);
      timer1_pin <= $random(seed);
      watchdog_prescaler_out <= $random(seed);
      timer1_overflow <= $random(seed);
      timer0_clkout <= $random(seed);
      timer1_clkout <= $random(seed);
    end
  end
  initial begin
    logic [7:0] d;
    logic [7:0] a;
    seed = 21; miscompares = 0; checked = 0; cycles = 0;
    rst = 1'b1; ce = 1'b1; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_addr = 8'h00;
    sfr_page = 4'h0; sfr_wdata = 8'h00; internal_rc_sel = 1'b1;
    ext_irq_zero = 1'b0; ext_irq_one = 1'b0; start_seen = 1'b0;
    stop_seen = 1'b0;
    ph = 0;
    master_clock = 1'b0;
    low_speed_rc = 1'b0;
    timer0_pin = 1'b0;
    timer1_pin = 1'b0;
    watchdog_prescaler_out = 1'b0;
    timer1_overflow = 1'b0;
    timer0_clkout = 1'b0;
    timer1_clkout = 1'b0;
    timer0_count_mode = 1'b0;
    timer1_count_mode = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(ADDR_PCIP + i, 4'h0, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PCIP + i, 4'h5, wm(ADDR_PCIP + i));
      rd(ADDR_PCIP + i, 4'h5, (i == 3) ? 8'h00 : wm(ADDR_PCIP + i));
      rd(ADDR_PCIP + i, 4'h0, (i == 3) ? PPR_RST : wm(ADDR_PCIP + i));
    end
    $display("test page and mask done");
    wr(ADDR_TCBF, 4'h0, 8'h05);
    pulse(1'b1);
    rd(ADDR_TCBF, 4'h9, 8'h85);
    pulse(1'b0);
    rd(ADDR_TCBF, 4'h0, 8'hc5);
    wr(ADDR_TCBF, 4'h0, 8'h05);
    rd(ADDR_TCBF, 4'h0, 8'h05);
    @(posedge clk);
    sfr_addr <= ADDR_TCBF;
    sfr_wdata <= 8'h05;
    sfr_wr <= 1'b1;
    start_seen <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    start_seen <= 1'b0;
    rd(ADDR_TCBF, 4'h0, 8'h85);
    $display("test bus flags done");
    for (int k = 0; k < 4; k++) begin
      ext_irq_zero <= k[1];
      ext_irq_one <= k[0];
      wr(ADDR_PCIP, 4'h2, {2'b00, k[0], 3'b000, k[1:0]});
      wr(ADDR_PSEL, 4'h0, {7'h00, k[0]});
      wr(ADDR_TCBF, 4'h0, {6'h00, k[1:0]});
      wr(ADDR_PPR, 4'h0, {k[1:0], 2'b00, k[0], k[1:0], 1'b0});
      @(negedge clk);
      cmp_out({3'h0, irq0_active}, {3'h0, ~(k[1] ^ k[0])});
      cmp_out({3'h0, irq1_active}, {3'h0, ~(k[1] ^ k[0])});
      cmp_out({3'h0, pointer_select_bit}, {3'h0, k[0]});
      cmp_out({3'h0, pin60_fast_drive}, {3'h0, k[0]});
      cmp_out({3'h0, timer0_clkout_pin}, {3'h0, timer0_clkout & k[0]});
      cmp_out({3'h0, timer1_clkout_pin}, {3'h0, timer1_clkout & k[1]});
      cmp_out(timer0_route, 4'h1 << k);
      cmp_out({3'h0, serial0_pin_select}, {3'h0, k[0]});
      cmp_out({2'h0, twowire0_pin_select}, {2'h0, k[1:0]});
    end
    $display("test output controls done");
    ce <= 1'b0;
    wr(ADDR_PSEL, 4'h0, 8'h00);
    ce <= 1'b1;
    rd(ADDR_PSEL, 4'h0, 8'h01);
    $display("test clock enable done");
    for (int i = 0; i < 12; i++) begin
      d = $random(seed);
      a = ADDR_PCIP + (i % 4);
      wr(a, 4'h0, d & wm(a));
      rd(a, 4'h0, d & wm(a));
    end
    $display("test random writes done");
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_PCIP, 4'h0, {c[1:0], 6'h00});
      @(negedge clk);
      cmp_out({3'h0, pin60_clock_en}, {3'h0, c != 0});
      if (c > 0) period(1'b0, MCK_PER << (c - 1));
    end
    @(posedge clk);
    internal_rc_sel <= 1'b0;
    @(negedge clk);
    cmp_out({3'h0, pin60_clock_en}, 4'h0);
    @(posedge clk);
    internal_rc_sel <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_PPR, 4'h0, {2'b00, b[1:0], 4'h0});
      @(negedge clk);
      cmp_out({3'h0, pin44_beeper_en}, {3'h0, b != 0});
      if (b > 0) period(1'b1, RC_PER * (64 >> b));
    end
    $display("test clock outputs done");
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_TCBF, 4'h0, {4'h0, m[1], m[1], 2'b00});
      wr(ADDR_PPR, 4'h0, {7'h00, m[2]});
      timer0_count_mode <= m[0];
      timer1_count_mode <= m[0];
      ticks(1'b0, m);
      if (m < 4) ticks(1'b1, m);
    end
    $display("test timer clocks done");
    repeat (2) @(posedge clk);
    report_and_stop;
  end
endmodule : acr_regs_tb
